//--- design/pfb_access_top.sv
// Host access to the packet buffers, length registers and bank selector.
module pfb_access_top
  import pfb_pkg::*;
#(
  parameter int DEPTH = PFB_BUF_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Serial register port, already decoded into single accesses
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire pfb_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  // Mode bits held elsewhere in the device
  input wire logic long_length_mode_i,
  input wire logic buf_read_sel_i,
  input wire logic tx_pointer_clear_i,
  input wire logic rx_pointer_clear_i,
  // Transmit side of the packet engine
  input wire logic tx_accept_done_i,
  input wire logic tx_complete_irq_i,
  input wire logic eng_tx_rd_i,
  output logic [7:0] eng_tx_data_o,
  output logic [15:0] tx_frame_length_o,
  output logic tx_access_error_o,
  // Receive side of the packet engine
  input wire logic rx_frame_start_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  input wire pfb_rx_byte_t rx_byte_i,
  input wire logic rx_length_valid_i,
  input wire logic [15:0] rx_frame_length_i,
  // Bank selection
  output logic [3:0] bank_select_o,
  output logic [3:0] bank_access_enable_o
);

  logic [7:0] bank_sel_r;
  logic [7:0] tx_len_hi_r;
  logic [7:0] tx_len_lo_r;
  logic [15:0] rx_len_r;
  logic [7:0] rdata_r;
  logic [7:0] eng_data_r;
  logic tx_stored_r;
  logic tx_err_r;
  logic [AW-1:0] tx_wr_ptr_r;
  logic [AW-1:0] tx_eng_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW-1:0] rx_wr_ptr_r;

  logic hit_tx_hi;
  logic hit_tx_lo;
  logic hit_tx_wr;
  logic hit_rx_hi;
  logic hit_rx_lo;
  logic hit_rd;
  logic hit_bank;
  logic tx_push;
  logic port_read;
  logic rx_port_read;
  logic rx_drain_ready;
  logic rx_drain_valid;
  pfb_rx_byte_t rx_drain_byte;
  logic rx_store;
  logic [7:0] tx_rd_host;
  logic [7:0] tx_rd_eng;
  logic [7:0] rx_rd_host;
  logic [7:0] read_mux;

  // Pointers wrap at the buffer depth. Nothing tracks the fill level, so a packet
  // longer than the buffer silently reuses the oldest slots.
  function automatic logic [AW-1:0] ptr_step(input logic [AW-1:0] ptr);
    ptr_step = ptr + AW'(1);
  endfunction : ptr_step

  // A clear that meets an access in the same cycle restarts at slot zero and
  // then counts that access, so the byte it moved is not moved again.
  function automatic logic [AW-1:0] ptr_restart(input logic access);
    ptr_restart = access ? AW'(1) : '0;
  endfunction : ptr_restart

  // Address decoding: the selector answers in every bank.
  assign hit_bank = (reg_req_i.addr == PFB_OFF_BANK_SEL);
  assign hit_tx_hi = pfb_bank0_hit(reg_req_i.addr, PFB_OFF_TX_LEN_H, bank_sel_r);
  assign hit_tx_lo = pfb_bank0_hit(reg_req_i.addr, PFB_OFF_TX_LEN_L, bank_sel_r);
  assign hit_tx_wr = pfb_bank0_hit(reg_req_i.addr, PFB_OFF_TX_WRITE, bank_sel_r);
  assign hit_rx_hi = pfb_bank0_hit(reg_req_i.addr, PFB_OFF_RX_LEN_H, bank_sel_r);
  assign hit_rx_lo = pfb_bank0_hit(reg_req_i.addr, PFB_OFF_RX_LEN_L, bank_sel_r);
  assign hit_rd = pfb_bank0_hit(reg_req_i.addr, PFB_OFF_READ_PORT, bank_sel_r);

  assign tx_push = reg_wr_i && hit_tx_wr;
  assign port_read = reg_rd_i && hit_rd;
  assign rx_port_read = port_read && !buf_read_sel_i;

  // Bank selector register.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      bank_sel_r <= PFB_RST_BANK_SEL;
    end else if (reg_wr_i && hit_bank) begin
      bank_sel_r <= reg_req_i.data;
    end
  end

  assign bank_select_o = bank_sel_r[PFB_BANK_SEL_LSB +: 4];
  assign bank_access_enable_o = bank_sel_r[PFB_BANK_EN_LSB +: 4];

  // Transmit length registers.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      tx_len_hi_r <= PFB_RST_BYTE;
      tx_len_lo_r <= PFB_RST_BYTE;
    end else begin
      if (reg_wr_i && hit_tx_hi) begin
        tx_len_hi_r <= reg_req_i.data;
      end
      if (reg_wr_i && hit_tx_lo) begin
        tx_len_lo_r <= reg_req_i.data;
      end
    end
  end

  assign tx_frame_length_o = long_length_mode_i ? {tx_len_hi_r, tx_len_lo_r} :
                             {8'h00, tx_len_lo_r};

  // One packet is held from acceptance until transmission completes.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      tx_stored_r <= 1'b0;
    end else if (tx_accept_done_i) begin
      tx_stored_r <= 1'b1;
    end else if (tx_complete_irq_i) begin
      tx_stored_r <= 1'b0;
    end
  end

  // The error is high for one cycle after each write to a held packet, for the interrupt controller to latch.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      tx_err_r <= 1'b0;
    end else begin
      tx_err_r <= tx_push && tx_stored_r;
    end
  end

  assign tx_access_error_o = tx_err_r;

  // Transmit write pointer; the byte is still written while a packet is held.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      tx_wr_ptr_r <= '0;
    end else if (tx_pointer_clear_i) begin
      tx_wr_ptr_r <= ptr_restart(tx_push);
    end else if (tx_push) begin
      tx_wr_ptr_r <= ptr_step(tx_wr_ptr_r);
    end
  end

  // Engine fetch pointer restarts when a new packet is accepted.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      tx_eng_ptr_r <= '0;
      eng_data_r <= PFB_RST_BYTE;
    end else if (tx_accept_done_i) begin
      tx_eng_ptr_r <= '0;
    end else if (eng_tx_rd_i) begin
      tx_eng_ptr_r <= ptr_step(tx_eng_ptr_r);
      eng_data_r <= tx_rd_eng;
    end
  end

  assign eng_tx_data_o = eng_data_r;

  pfb_byte_ram #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_tx_ram (
    .clk_sys_i(clk_sys_i),
    .wr_en_i(tx_push),
    .wr_addr_i(tx_wr_ptr_r),
    .wr_data_i(reg_req_i.data),
    .rd_addr_a_i(rd_ptr_r),
    .rd_data_a_o(tx_rd_host),
    .rd_addr_b_i(tx_eng_ptr_r),
    .rd_data_b_o(tx_rd_eng)
  );

  // Receive path. The host read port has priority over stores into the
  // receive buffer; the pair buffer absorbs the stall so no byte is lost.
  assign rx_drain_ready = !rx_port_read;
  assign rx_store = rx_drain_valid && rx_drain_ready;

  pfb_pair_buf #(
    .WIDTH($bits(pfb_rx_byte_t))
  ) u_rx_buf (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(rx_valid_i),
    .in_ready_o(rx_ready_o),
    .in_data_i(rx_byte_i),
    .out_valid_o(rx_drain_valid),
    .out_ready_i(rx_drain_ready),
    .out_data_o(rx_drain_byte)
  );

  // A new frame rewinds the store pointer, so it overwrites the old packet.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rx_wr_ptr_r <= '0;
    end else if (rx_frame_start_i) begin
      rx_wr_ptr_r <= '0;
    end else if (rx_store) begin
      rx_wr_ptr_r <= ptr_step(rx_wr_ptr_r);
    end
  end

  pfb_byte_ram #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_rx_ram (
    .clk_sys_i(clk_sys_i),
    .wr_en_i(rx_store && !rx_frame_start_i),
    .wr_addr_i(rx_wr_ptr_r),
    .wr_data_i(rx_drain_byte.data),
    .rd_addr_a_i(rd_ptr_r),
    .rd_data_a_o(rx_rd_host),
    .rd_addr_b_i(rx_wr_ptr_r),
    .rd_data_b_o()
  );

  // Received length as reported by the packet engine.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rx_len_r <= {PFB_RST_BYTE, PFB_RST_BYTE};
    end else if (rx_length_valid_i) begin
      rx_len_r <= rx_frame_length_i;
    end
  end

  // One read pointer serves both buffers, so an unfinished readback of the
  // transmit buffer shifts where a later receive read starts.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rd_ptr_r <= '0;
    end else if (rx_pointer_clear_i) begin
      rd_ptr_r <= ptr_restart(port_read);
    end else if (port_read) begin
      rd_ptr_r <= ptr_step(rd_ptr_r);
    end
  end

  assign read_mux = buf_read_sel_i ? tx_rd_host : rx_rd_host;

  // Read data register; unmapped or write-only addresses read as zero.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rdata_r <= PFB_RST_BYTE;
    end else if (reg_rd_i) begin
      if (hit_bank) begin
        rdata_r <= bank_sel_r;
      end else if (hit_tx_hi) begin
        rdata_r <= tx_len_hi_r;
      end else if (hit_tx_lo) begin
        rdata_r <= tx_len_lo_r;
      end else if (hit_rx_hi) begin
        rdata_r <= rx_len_r[15:8];
      end else if (hit_rx_lo) begin
        rdata_r <= rx_len_r[7:0];
      end else if (hit_rd) begin
        rdata_r <= read_mux;
      end else begin
        rdata_r <= PFB_RST_BYTE;
      end
    end
  end

  assign reg_rdata_o = rdata_r;

endmodule : pfb_access_top

//--- design/pfb_byte_ram.sv
// Byte storage in flip-flops with one write and two read ports.
module pfb_byte_ram
  import pfb_pkg::*;
#(
  parameter int DEPTH = PFB_BUF_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock
  input wire logic clk_sys_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  // Read ports
  input wire logic [AW-1:0] rd_addr_a_i,
  output logic [7:0] rd_data_a_o,
  input wire logic [AW-1:0] rd_addr_b_i,
  output logic [7:0] rd_data_b_o
);

  logic [7:0] mem_r [DEPTH];

  always_ff @(posedge clk_sys_i) begin
    if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
  end

  assign rd_data_a_o = mem_r[rd_addr_a_i];
  assign rd_data_b_o = mem_r[rd_addr_b_i];

endmodule : pfb_byte_ram

//--- design/pfb_pair_buf.sv
// Two-entry buffer with valid and ready on both sides.
module pfb_pair_buf
  import pfb_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  logic [WIDTH-1:0] slot_r [2];
  logic wr_idx_r;
  logic rd_idx_r;
  logic [1:0] count_r;
  logic push;
  logic pop;

  assign in_ready_o = (count_r != 2'h2);
  assign out_valid_o = (count_r != 2'h0);
  assign out_data_o = slot_r[rd_idx_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      slot_r[wr_idx_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      wr_idx_r <= 1'b0;
      rd_idx_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      if (push) begin
        wr_idx_r <= ~wr_idx_r;
      end
      if (pop) begin
        rd_idx_r <= ~rd_idx_r;
      end
      if (push && !pop) begin
        count_r <= count_r + 2'h1;
      end else if (pop && !push) begin
        count_r <= count_r - 2'h1;
      end
    end
  end

endmodule : pfb_pair_buf

//--- pkg/pfb_pkg.sv
// Constants, types and helpers shared by the packet buffer access block.
package pfb_pkg;

  // Register offsets.
  localparam logic [6:0] PFB_OFF_BANK_SEL = 7'h00;
  localparam logic [6:0] PFB_OFF_TX_LEN_H = 7'h7A;
  localparam logic [6:0] PFB_OFF_TX_LEN_L = 7'h7B;
  localparam logic [6:0] PFB_OFF_TX_WRITE = 7'h7C;
  localparam logic [6:0] PFB_OFF_RX_LEN_H = 7'h7D;
  localparam logic [6:0] PFB_OFF_RX_LEN_L = 7'h7E;
  localparam logic [6:0] PFB_OFF_READ_PORT = 7'h7F;

  // Reset values.
  localparam logic [7:0] PFB_RST_BANK_SEL = 8'h11;
  localparam logic [7:0] PFB_RST_BYTE = 8'h00;

  // Bank selector field layout.
  localparam int PFB_BANK_SEL_LSB = 0;
  localparam int PFB_BANK_EN_LSB = 4;
  localparam logic [3:0] PFB_BANK0_CODE = 4'h1;

  // Default buffer depth in bytes.
  localparam int PFB_BUF_DEPTH = 64;

  // One host access on the serial register port.
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } pfb_reg_req_t;

  // One received byte handed over by the packet engine.
  typedef struct packed {
    logic [7:0] data;
  } pfb_rx_byte_t;

  // True when the access targets a bank 0 register that is reachable.
  function automatic logic pfb_bank0_hit(input logic [6:0] addr, input logic [6:0] off,
                                         input logic [7:0] bank);
    pfb_bank0_hit = (addr == off) && (bank[PFB_BANK_SEL_LSB +: 4] == PFB_BANK0_CODE) &&
                    bank[PFB_BANK_EN_LSB];
  endfunction : pfb_bank0_hit

endpackage : pfb_pkg

//--- tb/pfb_access_checker.sv
// Port checks for the packet buffer access block.
module pfb_access_checker
  import pfb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire pfb_reg_req_t reg_req_i,
  input wire logic [7:0] reg_rdata_o,
  // Transmit side
  input wire logic long_length_mode_i,
  input wire logic tx_accept_done_i,
  input wire logic tx_complete_irq_i,
  input wire logic [15:0] tx_frame_length_o,
  input wire logic tx_access_error_o,
  // Receive side
  input wire logic rx_valid_i,
  input wire logic rx_ready_o,
  // Bank selection
  input wire logic [3:0] bank_select_o,
  input wire logic [3:0] bank_access_enable_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic b0_ok;
  logic held_r;
  assign b0_ok = bank_select_o == 4'h1 && bank_access_enable_o[0];
  // Window in which a packet sits in the transmit buffer; acceptance wins a tie.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      held_r <= 1'b0;
    end else if (tx_accept_done_i) begin
      held_r <= 1'b1;
    end else if (tx_complete_irq_i) begin
      held_r <= 1'b0;
    end
  end
  a_len_short_mode: assert property (!long_length_mode_i |->
    tx_frame_length_o[15:8] == 8'h00) else $error("high length byte counted in short mode");
  a_len_high_write: assert property ((reg_wr_i && reg_req_i.addr == 7'h7A && b0_ok
    ##1 long_length_mode_i) |-> tx_frame_length_o[15:8] == $past(reg_req_i.data))
    else $error("high length byte not taken");
  a_err_one_pulse: assert property (tx_access_error_o && !reg_wr_i |=>
    !tx_access_error_o) else $error("access error longer than one cycle");
  a_err_has_cause: assert property (tx_access_error_o |-> $past(reg_wr_i) &&
    $past(reg_req_i.addr) == 7'h7C) else $error("access error without a buffer write");
  a_err_on_overwrite: assert property (held_r && reg_wr_i &&
    reg_req_i.addr == 7'h7C && b0_ok |=> tx_access_error_o) else $error("overwrite not flagged");
  a_bank_reset: assert property ($rose(reset_n_i) |-> bank_select_o == 4'h1 &&
    bank_access_enable_o == 4'h1) else $error("bank selector reset value wrong");
  a_bank_write: assert property (reg_wr_i && reg_req_i.addr == 7'h00 |=>
    {bank_access_enable_o, bank_select_o} == $past(reg_req_i.data)) else $error("bank write lost");
  a_read_refused: assert property (reg_rd_i && reg_req_i.addr != 7'h00 && !b0_ok |=>
    reg_rdata_o == 8'h00) else $error("read through a closed bank");
  c_overwrite: cover property (tx_access_error_o);
  c_port_read: cover property (reg_rd_i && reg_req_i.addr == 7'h7F);
  c_rx_stall: cover property (rx_valid_i && !rx_ready_o);
endmodule : pfb_access_checker

bind pfb_access_top pfb_access_checker chk (.*);

//--- tb/pfb_host_model.sv
// Host processor model making single accesses on the register port.
module pfb_host_model
  import pfb_pkg::*;
(
  // Clock
  input wire logic clk_sys_i,
  // Register port
  input wire logic [7:0] host_rdata_i,
  output logic host_wr_o,
  output logic host_rd_o,
  output pfb_reg_req_t host_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    host_wr_o = 1'b0;
    host_rd_o = 1'b0;
    host_req_o = '0;
  end
  // one access at a time, never two strobes together
  task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge clk_sys_i);
    host_wr_o = w;
    host_rd_o = !w;
    host_req_o = '{addr: a, data: d};
    @(negedge clk_sys_i);
    host_wr_o = 1'b0;
    host_rd_o = 1'b0;
    // A released port shows no stale address or data.
    host_req_o = ~host_req_o;
    q = host_rdata_i;
  endtask : acc
endmodule : pfb_host_model

//--- tb/test_packet_fifo_bank_access.sv
// Self-checking bench for the packet buffer access block.
module test_packet_fifo_bank_access
  import pfb_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic reg_wr_i, reg_rd_i, long_length_mode_i, buf_read_sel_i, tx_pointer_clear_i;
  logic rx_pointer_clear_i, tx_accept_done_i, tx_complete_irq_i, eng_tx_rd_i;
  logic rx_frame_start_i, rx_valid_i, rx_ready_o, rx_length_valid_i, tx_access_error_o;
  pfb_reg_req_t reg_req_i;
  pfb_rx_byte_t rx_byte_i;
  logic [7:0] reg_rdata_o, eng_tx_data_o, q;
  logic [15:0] tx_frame_length_o, rx_frame_length_i;
  logic [3:0] bank_select_o, bank_access_enable_o, oh;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
  int i;
  always #10 clk_sys_i = ~clk_sys_i;
  pfb_access_top DUT (.*);
  pfb_host_model host (.clk_sys_i(clk_sys_i), .host_rdata_i(reg_rdata_o), .host_wr_o(reg_wr_i),
    .host_rd_o(reg_rd_i), .host_req_o(reg_req_i));
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    host.acc(1'b0, a, 8'h00, q);
    chk("read data", {8'h00, q}, {8'h00, e});
  endtask : rdc
  task automatic pulse(ref logic s);
    @(negedge clk_sys_i);
    s = 1'b1;
    @(negedge clk_sys_i);
    s = 1'b0;
  endtask : pulse
  task automatic push(input logic [7:0] d);
    @(negedge clk_sys_i);
    rx_valid_i = 1'b1;
    rx_byte_i = d;
    while (!rx_ready_o) @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    rx_valid_i = 1'b0;
    rx_byte_i = ~d;
  endtask : push
  task automatic close_out;
    $display("mismatches %0d num_checks %0d", mismatches, num_checks);
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    {long_length_mode_i, buf_read_sel_i, tx_pointer_clear_i, rx_pointer_clear_i} = '0;
    {tx_accept_done_i, tx_complete_irq_i, eng_tx_rd_i, rx_frame_start_i} = '0;
    {rx_valid_i, rx_length_valid_i} = '0;
    rx_byte_i = '0;
    rx_frame_length_i = 16'h0000;
    repeat (10) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    rdc(7'h00, 8'h11);
    for (i = 7'h7A; i < 7'h7F; i++) rdc(i[6:0], 8'h00);
    // the lengths written count the payload only
    host.acc(1'b1, 7'h7A, 8'h12, q);
    host.acc(1'b1, 7'h7B, 8'h34, q);
    chk("tx length", tx_frame_length_o, 16'h0034);
    long_length_mode_i = 1'b1;
    #1 chk("tx length", tx_frame_length_o, 16'h1234);
    host.acc(1'b1, 7'h7A, 8'h56, q);
    chk("tx length", tx_frame_length_o, 16'h5634);
    // write pointer cleared before a fresh packet
    pulse(tx_pointer_clear_i);
    for (i = 0; i < 4; i++) host.acc(1'b1, 7'h7C, 8'hA0 + i[7:0], q);
    pulse(rx_pointer_clear_i);
    buf_read_sel_i = 1'b1;
    for (i = 0; i < 4; i++) rdc(7'h7F, 8'hA0 + i[7:0]);
    pulse(tx_accept_done_i);
    pulse(eng_tx_rd_i);
    chk("engine byte", {8'h00, eng_tx_data_o}, 16'h00A0);
    host.acc(1'b1, 7'h7C, 8'hB5, q);
    chk("overwrite error", {15'h0000, tx_access_error_o}, 16'h0001);
    pulse(tx_complete_irq_i);
    host.acc(1'b1, 7'h7C, 8'hB6, q);
    chk("late write error", {15'h0000, tx_access_error_o}, 16'h0000);
    pulse(tx_pointer_clear_i);
    host.acc(1'b1, 7'h7C, 8'hC9, q);
    pulse(rx_pointer_clear_i);
    rdc(7'h7F, 8'hC9);
    pulse(rx_frame_start_i);
    for (i = 0; i < 3; i++) push(8'hD0 + i[7:0]);
    rx_frame_length_i = 16'h0103;
    pulse(rx_length_valid_i);
    rx_frame_length_i = 16'hFEFC;
    rdc(7'h7D, 8'h01);
    host.acc(1'b1, 7'h7E, 8'h55, q);
    rdc(7'h7E, 8'h03);
    // pointer cleared before the transmit read only; the receive read after it goes on from slot 1
    pulse(rx_pointer_clear_i);
    rdc(7'h7F, 8'hC9);
    buf_read_sel_i = 1'b0;
    rdc(7'h7F, 8'hD1);
    pulse(rx_pointer_clear_i);
    rdc(7'h7F, 8'hD0);
    pulse(rx_frame_start_i);
    push(8'hE0);
    pulse(rx_pointer_clear_i);
    rdc(7'h7F, 8'hE0);
    // A byte held on the input across a buffer read fills both entries.
    @(negedge clk_sys_i);
    rx_byte_i = 8'hF0;
    rx_valid_i = 1'b1;
    host.acc(1'b0, 7'h7F, 8'h00, q);
    chk("rx ready", {15'h0000, rx_ready_o}, 16'h0000);
    @(negedge clk_sys_i);
    rx_valid_i = 1'b0;
    chk("rx ready", {15'h0000, rx_ready_o}, 16'h0001);
    for (i = 0; i < 4; i++) begin
      oh = 4'(1 << i);
      host.acc(1'b1, 7'h00, {oh, oh}, q);
      chk("bank", {8'h00, bank_access_enable_o, bank_select_o}, {8'h00, oh, oh});
      rdc(7'h7A, i == 0 ? 8'h56 : 8'h00);
    end
    host.acc(1'b1, 7'h00, 8'h01, q);
    rdc(7'h7A, 8'h00);
    // A reset in mid-run must bring the selector back to bank 0.
    @(negedge clk_sys_i);
    reset_n_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    rdc(7'h00, 8'h11);
    rdc(7'h7A, 8'h00);
    close_out();
  end
endmodule : test_packet_fifo_bank_access
